// file: rtl/tcmp_timer.sv
// Purpose: 16-bit timer with normal and clear-on-match counting and two compare outputs
// Assumes: timer_tick is the prescaled step, one clk wide, made on clk
// Notes:   pwm modes count as normal here and disable the force strobe
//
// Contract
// - output mode field picks match action and pin source.
// - reset clears the internal compare output state to zero.
// - nonzero output mode replaces port output value with compare state.
// - pin direction always follows the port direction bit.
// - compare state can be prepared before pin is driven.
// - output mode field never touches capture behaviour.
// - output mode zero leaves compare state unchanged on matches.
// - a new output mode acts at the next match, unbuffered.
// - force strobe applies the configured action at once, non-pwm modes.
// - counting depends on waveform mode only.
// - non-pwm match sets, clears or toggles compare state.
// - mode zero increments and wraps from FFFF to 0000.
// - normal mode sets overflow flag as counter becomes zero.
// - overflow flag clears when its interrupt is taken.
// - software may write counter at any time.
// - clear-on-match clears at top: compare A in mode 4, capture in 12.
// - reaching top sets compare A flag or capture flag.
// - top is used unbuffered; a missed top runs through FFFF.
// - output mode 1 toggles channel A at each match.
// - toggle period is 2 times prescale times one plus compare A.
// - clear-on-match sets overflow flag when passing FFFF to 0000.
// - continuous compare, flag set on the matching timer cycle.
// - counter write suppresses matches in the next timer cycle.
// - forced compare touches only compare state, not flags or counter.
`timescale 1ns/1ps
`default_nettype none
`include "tcmp_params.svh"
module tcmp_timer
   import tcmp_pkg::*;
(
   // clock and reset
   input  wire logic                 clk,
   input  wire logic                 rst_b,
   // register port
   input  wire logic [`TCMP_AW-1:0]  reg_addr,
   input  wire logic [`TCMP_DW-1:0]  reg_wdata,
   input  wire logic                 reg_wr,
   input  wire logic                 reg_rd,
   output logic      [`TCMP_DW-1:0]  reg_rdata,
   // timer step and capture trigger
   input  wire logic                 timer_tick,
   input  wire logic                 capture_event,
   // interrupt taken
   input  wire logic                 ovf_ack,
   input  wire logic                 cmpa_ack,
   input  wire logic                 cmpb_ack,
   input  wire logic                 capt_ack,
   // flags
   output logic                      overflow_flag,
   output logic                      compare_flag_a,
   output logic                      compare_flag_b,
   output logic                      capture_flag,
   // compare pins
   output logic                      pin_a_o,
   output logic                      pin_a_oe,
   output logic                      pin_b_o,
   output logic                      pin_b_oe
);

   ////////////////////////////////////////////////////////////////////////////
   // helpers

   function automatic logic is_ctc(input tcmp_wgm_t m);
      is_ctc = (m == `TCMP_WGM_CTC_CMPA) || (m == `TCMP_WGM_CTC_CAPT);
   endfunction

   function automatic logic is_non_pwm(input tcmp_wgm_t m);
      is_non_pwm = (m == `TCMP_WGM_NORMAL) || is_ctc(m);
   endfunction

   function automatic logic hit(input logic strobe, input logic [`TCMP_AW-1:0] ofs);
      hit = strobe && (reg_addr == ofs);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // declarations

   tcmp_wgm_t  waveform_mode_q;
   tcmp_wgm_t  waveform_mode_d;
   tcmp_com_t  compare_output_mode_a_q;
   tcmp_com_t  compare_output_mode_a_d;
   tcmp_com_t  compare_output_mode_b_q;
   tcmp_com_t  compare_output_mode_b_d;
   tcmp_word_t compare_register_a_q;
   tcmp_word_t compare_register_a_d;
   tcmp_word_t compare_register_b_q;
   tcmp_word_t compare_register_b_d;
   tcmp_word_t capture_register_q;
   tcmp_word_t capture_register_d;
   logic [1:0] port_out_q;
   logic [1:0] port_out_d;
   logic [1:0] compare_pin_direction_bit_q;
   logic [1:0] compare_pin_direction_bit_d;
   logic [3:0] flags_q;
   logic [3:0] flags_d;
   logic       block_q;
   logic       block_d;
   logic [`TCMP_DW-1:0] rdata_q;
   logic [`TCMP_DW-1:0] rdata_d;

   tcmp_word_t counter_value;
   logic       compare_output_state_a;
   logic       compare_output_state_b;

   logic wr_ctrl;
   logic wr_force;
   logic wr_count;
   logic wr_cmpa;
   logic wr_cmpb;
   logic wr_capt;
   logic wr_flags;
   logic wr_port;
   logic match_a;
   logic match_b;
   logic match_capt;
   logic top_hit;
   logic wrap;
   logic force_a;
   logic force_b;
   logic capture_take;

   ////////////////////////////////////////////////////////////////////////////
   // write decode

   assign wr_ctrl  = hit(reg_wr, `TCMP_OFS_CTRL);
   assign wr_force = hit(reg_wr, `TCMP_OFS_FORCE);
   assign wr_count = hit(reg_wr, `TCMP_OFS_COUNT);
   assign wr_cmpa  = hit(reg_wr, `TCMP_OFS_CMPA);
   assign wr_cmpb  = hit(reg_wr, `TCMP_OFS_CMPB);
   assign wr_capt  = hit(reg_wr, `TCMP_OFS_CAPT);
   assign wr_flags = hit(reg_wr, `TCMP_OFS_FLAGS);
   assign wr_port  = hit(reg_wr, `TCMP_OFS_PORT);

   ////////////////////////////////////////////////////////////////////////////
   // compare and counter events

   // comparators see the live registers; nothing is double buffered here
   always_comb
   begin
      match_a    = timer_tick && !block_q
                   && (counter_value == compare_register_a_q);
      match_b    = timer_tick && !block_q
                   && (counter_value == compare_register_b_q);
      match_capt = timer_tick && !block_q
                   && (counter_value == capture_register_q);
      // a top written below the count is simply missed until after wrap
      case (waveform_mode_q)
         `TCMP_WGM_CTC_CMPA: top_hit = match_a;
         `TCMP_WGM_CTC_CAPT: top_hit = match_capt;
         default:            top_hit = 1'b0;
      endcase
      // a same-cycle counter write wins, so no wrap is seen then
      wrap = timer_tick && !wr_count
             && (counter_value == `TCMP_CNT_MAX);
      force_a = wr_force && reg_wdata[`TCMP_BIT_A]
                && is_non_pwm(waveform_mode_q);
      force_b = wr_force && reg_wdata[`TCMP_BIT_B]
                && is_non_pwm(waveform_mode_q);
      // capture input is idle while the capture register sets top
      capture_take = capture_event
                     && (waveform_mode_q != `TCMP_WGM_CTC_CAPT);
   end

   tcmp_counter u_counter (
      .clk     (clk),
      .rst_b   (rst_b),
      .tick    (timer_tick),
      .clear   (top_hit),
      .wr      (wr_count),
      .wr_val  (reg_wdata),
      .count_q (counter_value)
   );

   ////////////////////////////////////////////////////////////////////////////
   // match blocking after a counter write

   // held until the next tick, so a stopped timer still loses that match
   always_comb
   begin
      block_d = block_q;
      if (wr_count)
      begin
         block_d = 1'b1;
      end
      else if (timer_tick)
      begin
         block_d = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         block_q <= 1'b0;
      end
      else
      begin
         block_q <= block_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // configuration registers

   always_comb
   begin
      waveform_mode_d             = waveform_mode_q;
      compare_output_mode_a_d     = compare_output_mode_a_q;
      compare_output_mode_b_d     = compare_output_mode_b_q;
      compare_register_a_d        = compare_register_a_q;
      compare_register_b_d        = compare_register_b_q;
      capture_register_d          = capture_register_q;
      port_out_d                  = port_out_q;
      compare_pin_direction_bit_d = compare_pin_direction_bit_q;
      if (wr_ctrl)
      begin
         waveform_mode_d         = reg_wdata[`TCMP_CTRL_WGM_LSB +: 4];
         compare_output_mode_a_d = tcmp_com_t'(reg_wdata[`TCMP_CTRL_COMA_LSB +: 2]);
         compare_output_mode_b_d = tcmp_com_t'(reg_wdata[`TCMP_CTRL_COMB_LSB +: 2]);
      end
      if (wr_cmpa)
      begin
         compare_register_a_d = reg_wdata;
      end
      if (wr_cmpb)
      begin
         compare_register_b_d = reg_wdata;
      end
      // a capture event beats a software write of the same cycle
      if (capture_take)
      begin
         capture_register_d = counter_value;
      end
      else if (wr_capt)
      begin
         capture_register_d = reg_wdata;
      end
      if (wr_port)
      begin
         port_out_d                  = reg_wdata[1:0];
         compare_pin_direction_bit_d = reg_wdata[`TCMP_PORT_DIR_LSB +: 2];
      end
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         waveform_mode_q             <= `TCMP_RST_WGM;
         compare_output_mode_a_q     <= TCMP_COM_OFF;
         compare_output_mode_b_q     <= TCMP_COM_OFF;
         compare_register_a_q        <= `TCMP_RST_REG16;
         compare_register_b_q        <= `TCMP_RST_REG16;
         capture_register_q          <= `TCMP_RST_REG16;
         port_out_q                  <= `TCMP_RST_PORT;
         compare_pin_direction_bit_q <= `TCMP_RST_PORT;
      end
      else
      begin
         waveform_mode_q             <= waveform_mode_d;
         compare_output_mode_a_q     <= compare_output_mode_a_d;
         compare_output_mode_b_q     <= compare_output_mode_b_d;
         compare_register_a_q        <= compare_register_a_d;
         compare_register_b_q        <= compare_register_b_d;
         capture_register_q          <= capture_register_d;
         port_out_q                  <= port_out_d;
         compare_pin_direction_bit_q <= compare_pin_direction_bit_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // flags: write one or interrupt taken clears, hardware set wins

   always_comb
   begin
      flags_d = flags_q;
      if (wr_flags)
      begin
         flags_d = flags_q & ~reg_wdata[3:0];
      end
      if (ovf_ack)
      begin
         flags_d[`TCMP_FLG_OVF] = 1'b0;
      end
      if (cmpa_ack)
      begin
         flags_d[`TCMP_FLG_CMPA] = 1'b0;
      end
      if (cmpb_ack)
      begin
         flags_d[`TCMP_FLG_CMPB] = 1'b0;
      end
      if (capt_ack)
      begin
         flags_d[`TCMP_FLG_CAPT] = 1'b0;
      end
      if (wrap)
      begin
         flags_d[`TCMP_FLG_OVF] = 1'b1;
      end
      // forced compares never reach the flags
      if (match_a)
      begin
         flags_d[`TCMP_FLG_CMPA] = 1'b1;
      end
      if (match_b)
      begin
         flags_d[`TCMP_FLG_CMPB] = 1'b1;
      end
      if ((top_hit && (waveform_mode_q == `TCMP_WGM_CTC_CAPT)) || capture_take)
      begin
         flags_d[`TCMP_FLG_CAPT] = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         flags_q <= `TCMP_RST_FLAGS;
      end
      else
      begin
         flags_q <= flags_d;
      end
   end

   assign overflow_flag  = flags_q[`TCMP_FLG_OVF];
   assign compare_flag_a = flags_q[`TCMP_FLG_CMPA];
   assign compare_flag_b = flags_q[`TCMP_FLG_CMPB];
   assign capture_flag   = flags_q[`TCMP_FLG_CAPT];

   ////////////////////////////////////////////////////////////////////////////
   // compare output channels

   tcmp_wavegen u_wave_a (
      .clk       (clk),
      .rst_b     (rst_b),
      .com       (compare_output_mode_a_q),
      .match     (match_a),
      .force_cmp (force_a),
      .port_out  (port_out_q[`TCMP_BIT_A]),
      .port_dir  (compare_pin_direction_bit_q[`TCMP_BIT_A]),
      .state_q   (compare_output_state_a),
      .pin_o     (pin_a_o),
      .pin_oe    (pin_a_oe)
   );

   tcmp_wavegen u_wave_b (
      .clk       (clk),
      .rst_b     (rst_b),
      .com       (compare_output_mode_b_q),
      .match     (match_b),
      .force_cmp (force_b),
      .port_out  (port_out_q[`TCMP_BIT_B]),
      .port_dir  (compare_pin_direction_bit_q[`TCMP_BIT_B]),
      .state_q   (compare_output_state_b),
      .pin_o     (pin_b_o),
      .pin_oe    (pin_b_oe)
   );

   ////////////////////////////////////////////////////////////////////////////
   // read path: data one cycle after the strobe, zero otherwise

   always_comb
   begin
      rdata_d = '0;
      if (reg_rd)
      begin
         case (reg_addr)
            `TCMP_OFS_CTRL:
            begin
               rdata_d[`TCMP_CTRL_WGM_LSB +: 4]  = waveform_mode_q;
               rdata_d[`TCMP_CTRL_COMA_LSB +: 2] = compare_output_mode_a_q;
               rdata_d[`TCMP_CTRL_COMB_LSB +: 2] = compare_output_mode_b_q;
            end
            `TCMP_OFS_COUNT:  rdata_d = counter_value;
            `TCMP_OFS_CMPA:   rdata_d = compare_register_a_q;
            `TCMP_OFS_CMPB:   rdata_d = compare_register_b_q;
            `TCMP_OFS_CAPT:   rdata_d = capture_register_q;
            `TCMP_OFS_FLAGS:  rdata_d[3:0] = flags_q;
            `TCMP_OFS_PORT:
            begin
               rdata_d[1:0]                     = port_out_q;
               rdata_d[`TCMP_PORT_DIR_LSB +: 2] = compare_pin_direction_bit_q;
            end
            `TCMP_OFS_STATUS:
            begin
               rdata_d[`TCMP_BIT_A] = compare_output_state_a;
               rdata_d[`TCMP_BIT_B] = compare_output_state_b;
            end
            default:          rdata_d = '0;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rdata_q <= '0;
      end
      else
      begin
         rdata_q <= rdata_d;
      end
   end

   assign reg_rdata = rdata_q;

endmodule
`default_nettype wire

// file: rtl/tcmp_params.svh
// Purpose: offsets, field positions, reset values and widths of the timer compare block
// Assumes: register port with 4-bit word index and 16-bit data
// Notes:   definitions only
`ifndef TCMP_PARAMS_SVH
`define TCMP_PARAMS_SVH

`define TCMP_AW            4
`define TCMP_DW            16
`define TCMP_CNT_MAX       16'hFFFF
`define TCMP_CNT_BOTTOM    16'h0000

// register indices
`define TCMP_OFS_CTRL      4'h0
`define TCMP_OFS_FORCE     4'h1
`define TCMP_OFS_COUNT     4'h2
`define TCMP_OFS_CMPA      4'h3
`define TCMP_OFS_CMPB      4'h4
`define TCMP_OFS_CAPT      4'h5
`define TCMP_OFS_FLAGS     4'h6
`define TCMP_OFS_PORT      4'h7
`define TCMP_OFS_STATUS    4'h8

// control fields
`define TCMP_CTRL_WGM_LSB  0
`define TCMP_CTRL_COMA_LSB 4
`define TCMP_CTRL_COMB_LSB 6
// force, status and port bits
`define TCMP_BIT_A         0
`define TCMP_BIT_B         1
`define TCMP_PORT_DIR_LSB  2
// flag bits
`define TCMP_FLG_OVF       0
`define TCMP_FLG_CMPA      1
`define TCMP_FLG_CMPB      2
`define TCMP_FLG_CAPT      3

// waveform modes handled here
`define TCMP_WGM_NORMAL    4'h0
`define TCMP_WGM_CTC_CMPA  4'h4
`define TCMP_WGM_CTC_CAPT  4'hC

// reset values
`define TCMP_RST_WGM       4'h0
`define TCMP_RST_REG16     16'h0000
`define TCMP_RST_FLAGS     4'h0
`define TCMP_RST_PORT      2'h0

`endif

// file: rtl/tcmp_pkg.sv
// Purpose: shared types of the timer compare block
// Assumes: nothing
// Notes:   enum order gives the two-bit field encoding
package tcmp_pkg;

   typedef enum logic [1:0] {
      TCMP_COM_OFF,
      TCMP_COM_TOGGLE,
      TCMP_COM_CLEAR,
      TCMP_COM_SET
   } tcmp_com_t;

   typedef logic [3:0]  tcmp_wgm_t;
   typedef logic [15:0] tcmp_word_t;

endpackage

// file: rtl/tcmp_counter.sv
// Purpose: 16-bit up counter stepped by the timer tick
// Assumes: tick, clear and write come from logic on clk
// Notes:   a software write wins over counting in the same cycle
`timescale 1ns/1ps
`default_nettype none
`include "tcmp_params.svh"
module tcmp_counter
   import tcmp_pkg::*;
(
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst_b,
   // control
   input  wire logic       tick,
   input  wire logic       clear,
   input  wire logic       wr,
   input  wire tcmp_word_t wr_val,
   // value
   output tcmp_word_t      count_q
);

   tcmp_word_t count_d;

   always_comb
   begin
      count_d = count_q;
      if (wr)
      begin
         count_d = wr_val;
      end
      else if (tick)
      begin
         if (clear)
         begin
            count_d = `TCMP_CNT_BOTTOM;
         end
         else
         begin
            count_d = count_q + 16'h0001;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         count_q <= `TCMP_RST_REG16;
      end
      else
      begin
         count_q <= count_d;
      end
   end

endmodule
`default_nettype wire

// file: rtl/tcmp_wavegen.sv
// Purpose: one compare output state and its pin override
// Assumes: match and force are one-cycle pulses on clk
// Notes:   state is kept across mode changes
`timescale 1ns/1ps
`default_nettype none
module tcmp_wavegen
   import tcmp_pkg::*;
(
   // clock and reset
   input  wire logic      clk,
   input  wire logic      rst_b,
   // events
   input  wire tcmp_com_t com,
   input  wire logic      match,
   input  wire logic      force_cmp,
   // port register bits
   input  wire logic      port_out,
   input  wire logic      port_dir,
   // outputs
   output logic           state_q,
   output logic           pin_o,
   output logic           pin_oe
);

   logic state_d;

   // com is read live, so a new setting acts on the next event
   always_comb
   begin
      state_d = state_q;
      if (match || force_cmp)
      begin
         case (com)
            TCMP_COM_OFF:    state_d = state_q;
            TCMP_COM_TOGGLE: state_d = !state_q;
            TCMP_COM_CLEAR:  state_d = 1'b0;
            TCMP_COM_SET:    state_d = 1'b1;
            default:         state_d = state_q;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         state_q <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
      end
   end

   // state may be prepared while the pin is still an input
   assign pin_o  = (com != TCMP_COM_OFF) ? state_q : port_out;
   assign pin_oe = port_dir;

endmodule
`default_nettype wire

// file: dv/tcmp_timer_chk.sv
// Purpose: port-level properties of the timer compare block
// Assumes: single clock, rst_b asynchronous active low
// Notes:   bound to every tcmp_timer instance
`timescale 1ns/1ps
`default_nettype none
`include "tcmp_params.svh"
module tcmp_timer_chk
(
   // clock and reset
   input  wire logic                clk,
   input  wire logic                rst_b,
   // register port and events
   input  wire logic [`TCMP_AW-1:0] reg_addr,
   input  wire logic [`TCMP_DW-1:0] reg_wdata,
   input  wire logic                reg_wr,
   input  wire logic                timer_tick,
   input  wire logic                ovf_ack,
   // observed outputs
   input  wire logic                overflow_flag,
   input  wire logic                compare_flag_a,
   input  wire logic                pin_a_o,
   input  wire logic                pin_a_oe
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   sequence s_wr(logic [3:0] a);
      reg_wr && reg_addr == a;
   endsequence
   // overflow and compare flags are only set on a tick, so a quiet edge isolates the clear paths
   a_dir_to_oe: assert property (s_wr(`TCMP_OFS_PORT) |=>
      pin_a_oe == $past(reg_wdata[`TCMP_PORT_DIR_LSB])) else $error("pin a enable wrong");
   a_ovf_ack: assert property (ovf_ack && !timer_tick |=> !overflow_flag)
      else $error("overflow flag not cleared by ack");
   a_ovf_tick: assert property ($rose(overflow_flag) |-> $past(timer_tick))
      else $error("overflow flag set without tick");
   a_cmpa_tick: assert property ($rose(compare_flag_a) |-> $past(timer_tick))
      else $error("compare flag a set without tick");
   a_force_noflag: assert property (s_wr(`TCMP_OFS_FORCE) ##0 !timer_tick |=>
      !$rose(compare_flag_a)) else $error("force set compare flag");
   a_pin_cause: assert property ($changed(pin_a_o) |-> $past(timer_tick || reg_wr))
      else $error("pin a moved without cause");
   a_ovf_holds: assert property (overflow_flag && !ovf_ack &&
      !(reg_wr && reg_addr == `TCMP_OFS_FLAGS) |=> overflow_flag) else $error("overflow lost");
   a_flag_wclr: assert property (s_wr(`TCMP_OFS_FLAGS) ##0 !timer_tick
      ##0 reg_wdata[`TCMP_FLG_OVF] |=> !overflow_flag) else $error("flag write no clear");
endmodule
bind tcmp_timer tcmp_timer_chk u_tcmp_timer_chk (.clk(clk), .rst_b(rst_b),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .timer_tick(timer_tick),
   .ovf_ack(ovf_ack), .overflow_flag(overflow_flag), .compare_flag_a(compare_flag_a),
   .pin_a_o(pin_a_o), .pin_a_oe(pin_a_oe));
`default_nettype wire

// file: dv/tb_tcmp_timer.sv
// Purpose: directed bench of the timer compare block
// Assumes: tasks start on a rising edge and end 1 ns after one
// Notes:   no prescaler here, ticks come straight from the bench
`timescale 1ns/1ps
`default_nettype none
`include "tcmp_params.svh"
module tb_tcmp_timer import tcmp_pkg::*;;
   logic       clk = 1'h0, rst_b = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0;
   logic       timer_tick = 1'h0, capture_event = 1'h0, ovf_ack = 1'h0;
   logic       cmpa_ack = 1'h0, cmpb_ack = 1'h0, capt_ack = 1'h0;
   logic       ovf_f, cmpa_f, cmpb_f, capt_f, pa_o, pa_oe, pb_o, pb_oe;
   logic [3:0] reg_addr = 4'h0;
   tcmp_word_t reg_wdata = 16'h0000, reg_rdata, rd_q;
   int         miscompares = 0, n_compared = 0;
   tcmp_timer u_tcmp_timer (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .timer_tick(timer_tick), .capture_event(capture_event), .ovf_ack(ovf_ack),
      .cmpa_ack(cmpa_ack), .cmpb_ack(cmpb_ack), .capt_ack(capt_ack), .overflow_flag(ovf_f),
      .compare_flag_a(cmpa_f), .compare_flag_b(cmpb_f), .capture_flag(capt_f),
      .pin_a_o(pa_o), .pin_a_oe(pa_oe), .pin_b_o(pb_o), .pin_b_oe(pb_oe));
   always #50 clk = ~clk;
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input tcmp_word_t seen, input tcmp_word_t exp);
      n_compared++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic report_and_stop();
      if (miscompares == 0 && n_compared > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic wr(input logic [3:0] a, input tcmp_word_t d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'h1;
      @(posedge clk);
      reg_wr <= 1'h0;
      #1;
   endtask
   task automatic rd(input logic [3:0] a);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'h1;
      @(posedge clk);
      reg_rd <= 1'h0;
      #1;
      rd_q = reg_rdata;
   endtask
   task automatic tk(input int n);
      @(posedge clk);
      timer_tick <= 1'h1;
      repeat (n) @(posedge clk);
      timer_tick <= 1'h0;
      #1;
   endtask
   task automatic ctl(input logic [3:0] w, input logic [1:0] ca);
      wr(`TCMP_OFS_CTRL, {8'h00, 2'h0, ca, w});
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // state is prepared by force while the pin is still undriven
   task automatic t_force();
      ctl(`TCMP_WGM_NORMAL, TCMP_COM_SET);
      wr(`TCMP_OFS_COUNT, 16'h0010);
      wr(`TCMP_OFS_FORCE, 16'h0001);
      chk({cmpa_f, pa_oe}, 16'h0000);
      rd(`TCMP_OFS_STATUS);
      chk(rd_q, 16'h0001);
      wr(`TCMP_OFS_PORT, 16'h0004);
      chk({pa_oe, pa_o}, 16'h0003);
      ctl(`TCMP_WGM_NORMAL, TCMP_COM_CLEAR);
      wr(`TCMP_OFS_FORCE, 16'h0001);
      chk(pa_o, 16'h0000);
      ctl(`TCMP_WGM_NORMAL, TCMP_COM_TOGGLE);
      wr(`TCMP_OFS_FORCE, 16'h0001);
      chk(pa_o, 16'h0001);
      ctl(`TCMP_WGM_NORMAL, TCMP_COM_OFF);
      wr(`TCMP_OFS_FORCE, 16'h0001);
      chk(pa_o, 16'h0000);
      rd(`TCMP_OFS_STATUS);
      chk(rd_q, 16'h0001);
      rd(`TCMP_OFS_COUNT);
      chk(rd_q, 16'h0010);
      // pwm codes ignore the force strobe
      ctl(4'h1, TCMP_COM_CLEAR);
      wr(`TCMP_OFS_FORCE, 16'h0001);
      rd(`TCMP_OFS_STATUS);
      chk(rd_q, 16'h0001);
   endtask
   task automatic t_ctc();
      ctl(`TCMP_WGM_CTC_CMPA, TCMP_COM_TOGGLE);
      wr(`TCMP_OFS_CMPA, 16'h0002);
      wr(`TCMP_OFS_COUNT, 16'h0000);
      wr(`TCMP_OFS_FLAGS, 16'h000F);
      tk(2);
      chk({cmpa_f, pa_o}, 16'h0001);
      tk(1);
      chk({cmpa_f, pa_o}, 16'h0002);
      rd(`TCMP_OFS_COUNT);
      chk(rd_q, 16'h0000);
      tk(2);
      chk(pa_o, 16'h0000);
      tk(1);
      chk(pa_o, 16'h0001);
   endtask
   // count above top: no match until the run through the maximum
   task automatic t_wrap();
      wr(`TCMP_OFS_COUNT, 16'hFFFD);
      tk(3);
      chk({ovf_f, pa_o}, 16'h0003);
      rd(`TCMP_OFS_COUNT);
      chk(rd_q, 16'h0000);
      @(posedge clk) ovf_ack <= 1'h1;
      @(posedge clk) ovf_ack <= 1'h0;
      #1;
      chk(ovf_f, 16'h0000);
      ctl(`TCMP_WGM_NORMAL, TCMP_COM_OFF);
      wr(`TCMP_OFS_COUNT, 16'hFFFF);
      tk(4);
      chk(ovf_f, 16'h0001);
      rd(`TCMP_OFS_COUNT);
      chk(rd_q, 16'h0003);
   endtask
   task automatic t_block();
      // channel b: set on match, port bit high so the override shows
      wr(`TCMP_OFS_CTRL, 16'h00C0);
      wr(`TCMP_OFS_PORT, 16'h000A);
      wr(`TCMP_OFS_CMPB, 16'h0020);
      wr(`TCMP_OFS_COUNT, 16'h0020);
      wr(`TCMP_OFS_FLAGS, 16'h000F);
      repeat (3) @(posedge clk);
      tk(1);
      chk(cmpb_f, 16'h0000);
      chk({pb_oe, pb_o}, 16'h0002);
      wr(`TCMP_OFS_COUNT, 16'h001F);
      tk(2);
      chk(cmpb_f, 16'h0001);
      chk(pb_o, 16'h0001);
   endtask
   task automatic t_capt();
      ctl(`TCMP_WGM_CTC_CAPT, TCMP_COM_OFF);
      wr(`TCMP_OFS_CAPT, 16'h0001);
      wr(`TCMP_OFS_COUNT, 16'h0000);
      wr(`TCMP_OFS_FLAGS, 16'h000F);
      tk(2);
      chk({capt_f, cmpa_f}, 16'h0002);
      rd(`TCMP_OFS_COUNT);
      chk(rd_q, 16'h0000);
      for (int i = 0; i < 4; i++)
      begin
         ctl(`TCMP_WGM_NORMAL, i[1:0]);
         wr(`TCMP_OFS_COUNT, tcmp_word_t'(16'h0040 + i));
         @(posedge clk) capture_event <= 1'h1;
         @(posedge clk) capture_event <= 1'h0;
         rd(`TCMP_OFS_CAPT);
         chk(rd_q, tcmp_word_t'(16'h0040 + i));
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (12) @(posedge clk);
      rst_b <= 1'h1;
      rd(`TCMP_OFS_STATUS);
      chk({rd_q[1:0], ovf_f, cmpa_f, cmpb_f, capt_f, pa_o, pa_oe}, 16'h0000);
      t_force();
      t_ctc();
      t_wrap();
      t_block();
      t_capt();
      report_and_stop();
   end
   // the whole sequence takes about 150 cycles
   initial
   begin
      #300000;
      miscompares++;
      report_and_stop();
   end
endmodule
`default_nettype wire
